// ==== logic/uhcr_pkg.sv ====
package uhcr_pkg;

    // Register byte addresses in the microcontroller memory map
    localparam logic [15:0] ADDR_VID_LO = 16'h7fa0;
    localparam logic [15:0] ADDR_VID_HI = 16'h7fa1;
    localparam logic [15:0] ADDR_PID_LO = 16'h7fa2;
    localparam logic [15:0] ADDR_PID_HI = 16'h7fa3;
    localparam logic [15:0] ADDR_REL_LO = 16'h7fa4;
    localparam logic [15:0] ADDR_REL_HI = 16'h7fa5;
    localparam logic [15:0] ADDR_CTRL = 16'h7fa6;
    localparam logic [15:0] ADDR_RSVD = 16'h7fa7;

    // Register indices inside the block
    localparam logic [2:0] IDX_VID_LO = 3'h0;
    localparam logic [2:0] IDX_VID_HI = 3'h1;
    localparam logic [2:0] IDX_PID_LO = 3'h2;
    localparam logic [2:0] IDX_PID_HI = 3'h3;
    localparam logic [2:0] IDX_REL_LO = 3'h4;
    localparam logic [2:0] IDX_REL_HI = 3'h5;
    localparam logic [2:0] IDX_CTRL = 3'h6;
    localparam logic [2:0] IDX_RSVD = 3'h7;

    // Hub control register fields
    localparam int CTRL_HOLD_N_BIT = 7;
    localparam int CTRL_RSVD_BIT = 6;
    localparam int CTRL_ROUTE_LO_BIT = 2;
    localparam int NUM_DS_PORTS = 4;
    localparam int NUM_XCVR = 5;

    // Reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] ID_RESET = 8'h00;
    localparam logic [7:0] RSVD_READ = 8'h00;

    // Token packet identifiers
    localparam logic [3:0] PID_OUT = 4'h1;
    localparam logic [3:0] PID_IN = 4'h9;
    localparam logic [3:0] PID_SETUP = 4'hd;

    // Firmware setup window after reset release
    localparam int SETUP_WINDOW_MS = 2;
    localparam int CLK_MHZ = 100;
    localparam int SETUP_WINDOW_CYCLES = SETUP_WINDOW_MS * 1000 * 1000 * CLK_MHZ / 1000;
    localparam int SETUP_TIMER_W = 18;

    typedef enum logic [1:0] {
        HUB_HOLD,
        HUB_RUN
    } uhcr_hub_state_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } uhcr_mcu_req_t;

    typedef struct packed {
        logic valid;
        logic [3:0] pid;
        logic [6:0] addr;
    } uhcr_token_t;

    typedef struct packed {
        uhcr_hub_state_t state;
        logic [15:0] vendor_id;
        logic [15:0] product_id;
        logic [15:0] release_number;
        logic [7:0] ctrl;
        logic [7:0] rdata;
        logic rvalid;
        logic hub_sel;
        logic bay_sel;
        logic [NUM_DS_PORTS-1:0] port_en;
        logic [NUM_DS_PORTS:0] on_hub;
        logic [NUM_XCVR-1:0] xcvr_en;
        logic [SETUP_TIMER_W-1:0] timer;
        logic window_open;
        logic setup_late;
    } uhcr_state_t;

    function automatic logic is_token(input logic [3:0] pid);
        return (pid == PID_SETUP) || (pid == PID_IN) || (pid == PID_OUT);
    endfunction

    function automatic logic in_block(input logic [15:0] addr);
        return addr[15:3] == ADDR_VID_LO[15:3];
    endfunction

endpackage

// ==== logic/uhcr_token_match.sv ====
module uhcr_token_match (
    input uhcr_pkg::uhcr_token_t tok,
    input logic [6:0] dev_addr,
    output logic match
);

    // Only SETUP, IN and OUT carry a device address worth comparing
    assign match = tok.valid && uhcr_pkg::is_token(tok.pid) && (tok.addr == dev_addr);

endmodule // uhcr_token_match

// ==== logic/uhcr_regs.sv ====
module uhcr_regs #(
    parameter int SETUP_CYCLES = uhcr_pkg::SETUP_WINDOW_CYCLES
) (
    input logic sys_clk,
    input logic nrst,
    input uhcr_pkg::uhcr_mcu_req_t mcu_req,
    output logic [7:0] mcu_rdata,
    output logic mcu_rvalid,
    input uhcr_pkg::uhcr_token_t token,
    input logic [6:0] hub_dev_addr,
    input logic [6:0] bay_dev_addr,
    input logic [3:0] host_port_enable,
    input logic [3:0] host_port_disable,
    output logic hub_ep_select,
    output logic bay_ep_select,
    output logic [15:0] vendor_id,
    output logic [15:0] product_id,
    output logic [15:0] release_number,
    output logic hub_controller_hold_n,
    output logic hub_requests_accept,
    output logic route_function_to_port5,
    output logic route_function_to_port4,
    output logic route_function_to_port3,
    output logic route_function_to_port2,
    output logic [4:0] port_on_hub,
    output logic [3:0] port_enabled,
    output logic [4:0] xcvr_enable,
    output logic setup_window_open,
    output logic setup_late
);

    localparam logic [uhcr_pkg::SETUP_TIMER_W-1:0] TIMER_LAST =
        uhcr_pkg::SETUP_TIMER_W'(SETUP_CYCLES - 1);

    uhcr_pkg::uhcr_state_t s_q;
    uhcr_pkg::uhcr_state_t s_d;
    logic hub_match;
    logic bay_match;
    logic wr_hit;
    logic rd_hit;
    logic [2:0] idx;
    logic [3:0] route;

    // Two independent decoders; the bay endpoint lives outside the hub logic
    uhcr_token_match u_hub_match (
        .tok(token),
        .dev_addr(hub_dev_addr),
        .match(hub_match)
    );

    uhcr_token_match u_bay_match (
        .tok(token),
        .dev_addr(bay_dev_addr),
        .match(bay_match)
    );

    assign idx = mcu_req.addr[2:0];
    assign wr_hit = mcu_req.wr && uhcr_pkg::in_block(mcu_req.addr);
    assign rd_hit = mcu_req.rd && uhcr_pkg::in_block(mcu_req.addr);

    always_comb begin
        s_d = s_q;
        s_d.rvalid = 1'b0;
        s_d.rdata = 8'h00;

        // Register writes; the reserved slot is not backed by storage
        if (wr_hit) begin
            case (idx)
                uhcr_pkg::IDX_VID_LO: s_d.vendor_id[7:0] = mcu_req.wdata;
                uhcr_pkg::IDX_VID_HI: s_d.vendor_id[15:8] = mcu_req.wdata;
                uhcr_pkg::IDX_PID_LO: s_d.product_id[7:0] = mcu_req.wdata;
                uhcr_pkg::IDX_PID_HI: s_d.product_id[15:8] = mcu_req.wdata;
                uhcr_pkg::IDX_REL_LO: s_d.release_number[7:0] = mcu_req.wdata;
                uhcr_pkg::IDX_REL_HI: s_d.release_number[15:8] = mcu_req.wdata;
                uhcr_pkg::IDX_CTRL: s_d.ctrl = mcu_req.wdata;
                default: s_d.ctrl = s_q.ctrl;
            endcase
        end

        // Reads return the value before any write in the same cycle
        if (rd_hit) begin
            s_d.rvalid = 1'b1;
            case (idx)
                uhcr_pkg::IDX_VID_LO: s_d.rdata = s_q.vendor_id[7:0];
                uhcr_pkg::IDX_VID_HI: s_d.rdata = s_q.vendor_id[15:8];
                uhcr_pkg::IDX_PID_LO: s_d.rdata = s_q.product_id[7:0];
                uhcr_pkg::IDX_PID_HI: s_d.rdata = s_q.product_id[15:8];
                uhcr_pkg::IDX_REL_LO: s_d.rdata = s_q.release_number[7:0];
                uhcr_pkg::IDX_REL_HI: s_d.rdata = s_q.release_number[15:8];
                uhcr_pkg::IDX_CTRL: s_d.rdata = s_q.ctrl;
                default: s_d.rdata = uhcr_pkg::RSVD_READ;
            endcase
        end

        // Hub controller hold follows the control register bit
        case (s_q.state)
            uhcr_pkg::HUB_HOLD: begin
                if (s_d.ctrl[uhcr_pkg::CTRL_HOLD_N_BIT]) begin
                    s_d.state = uhcr_pkg::HUB_RUN;
                end
            end
            uhcr_pkg::HUB_RUN: begin
                if (!s_d.ctrl[uhcr_pkg::CTRL_HOLD_N_BIT]) begin
                    s_d.state = uhcr_pkg::HUB_HOLD;
                end
            end
            default: s_d.state = uhcr_pkg::HUB_HOLD;
        endcase

        // Hub endpoint traffic is dropped while the controller is held
        s_d.hub_sel = hub_match && (s_q.state == uhcr_pkg::HUB_RUN);
        s_d.bay_sel = bay_match;

        // Routing: overlapping bits give overlapping routes, as firmware was warned
        route = s_d.ctrl[uhcr_pkg::CTRL_ROUTE_LO_BIT +: uhcr_pkg::NUM_DS_PORTS];
        s_d.on_hub[0] = ~|route;
        for (int p = 0; p < uhcr_pkg::NUM_DS_PORTS; p++) begin
            s_d.on_hub[p+1] = !route[p];
            // A routed port is under the function, not under host port control
            if (s_d.state != uhcr_pkg::HUB_RUN || route[p]) begin
                s_d.port_en[p] = 1'b0;
            end else if (host_port_enable[p]) begin
                s_d.port_en[p] = 1'b1;
            end else if (host_port_disable[p]) begin
                s_d.port_en[p] = 1'b0;
            end
            s_d.xcvr_en[p+1] = s_d.port_en[p] || route[p];
        end
        s_d.xcvr_en[0] = (s_d.state == uhcr_pkg::HUB_RUN);

        // Watch whether firmware released the hub inside the setup window
        if (s_q.window_open) begin
            if (s_d.state == uhcr_pkg::HUB_RUN) begin
                s_d.window_open = 1'b0;
            end else if (s_q.timer == TIMER_LAST) begin
                s_d.window_open = 1'b0;
                s_d.setup_late = 1'b1;
            end else begin
                s_d.timer = s_q.timer + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '{
                state: uhcr_pkg::HUB_HOLD,
                vendor_id: {uhcr_pkg::ID_RESET, uhcr_pkg::ID_RESET},
                product_id: {uhcr_pkg::ID_RESET, uhcr_pkg::ID_RESET},
                release_number: {uhcr_pkg::ID_RESET, uhcr_pkg::ID_RESET},
                ctrl: uhcr_pkg::CTRL_RESET,
                rdata: 8'h00,
                rvalid: 1'b0,
                hub_sel: 1'b0,
                bay_sel: 1'b0,
                port_en: 4'h0,
                on_hub: 5'h1f,
                xcvr_en: 5'h00,
                timer: '0,
                window_open: 1'b1,
                setup_late: 1'b0
            };
        end else begin
            s_q <= s_d;
        end
    end

    assign mcu_rdata = s_q.rdata;
    assign mcu_rvalid = s_q.rvalid;
    assign hub_ep_select = s_q.hub_sel;
    assign bay_ep_select = s_q.bay_sel;
    assign vendor_id = s_q.vendor_id;
    assign product_id = s_q.product_id;
    assign release_number = s_q.release_number;
    assign hub_controller_hold_n = s_q.ctrl[uhcr_pkg::CTRL_HOLD_N_BIT];
    assign hub_requests_accept = (s_q.state == uhcr_pkg::HUB_RUN);
    assign route_function_to_port5 = s_q.ctrl[5];
    assign route_function_to_port4 = s_q.ctrl[4];
    assign route_function_to_port3 = s_q.ctrl[3];
    assign route_function_to_port2 = s_q.ctrl[2];
    assign port_on_hub = s_q.on_hub;
    assign port_enabled = s_q.port_en;
    assign xcvr_enable = s_q.xcvr_en;
    assign setup_window_open = s_q.window_open;
    assign setup_late = s_q.setup_late;

    sequence seq_ctrl_write(logic [7:0] v);
        wr_hit && idx == uhcr_pkg::IDX_CTRL && mcu_req.wdata == v;
    endsequence

    sequence seq_hub_token;
        token.valid && uhcr_pkg::is_token(token.pid) && token.addr == hub_dev_addr;
    endsequence

    AST_HOLD_DROPS_TOKEN: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        seq_hub_token ##0 !hub_requests_accept |=> !hub_ep_select)
        else $error("hub token selected while controller held");

    AST_RUN_SELECTS_TOKEN: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        seq_hub_token ##0 hub_requests_accept |=> hub_ep_select)
        else $error("hub token not selected while running");

    AST_BAY_DECODE: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        token.valid && uhcr_pkg::is_token(token.pid) && token.addr == bay_dev_addr
        |=> bay_ep_select)
        else $error("bay endpoint token not selected");

    AST_NON_TOKEN_IGNORED: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        !(token.valid && uhcr_pkg::is_token(token.pid)) |=> !hub_ep_select && !bay_ep_select)
        else $error("endpoint selected without a token");

    AST_VID_READBACK: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        wr_hit && idx == uhcr_pkg::IDX_VID_HI ##1 !wr_hit
        ##1 rd_hit && idx == uhcr_pkg::IDX_VID_HI
        |=> mcu_rvalid && mcu_rdata == $past(mcu_req.wdata, 3))
        else $error("vendor id high byte read back wrong");

    AST_VID_LOW_STORE: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        wr_hit && idx == uhcr_pkg::IDX_VID_LO |=> vendor_id[7:0] == $past(mcu_req.wdata))
        else $error("vendor id low byte not stored");

    AST_PID_LOW_STORE: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        wr_hit && idx == uhcr_pkg::IDX_PID_LO |=> product_id[7:0] == $past(mcu_req.wdata))
        else $error("product id low byte not stored");

    AST_PID_HIGH_STORE: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        wr_hit && idx == uhcr_pkg::IDX_PID_HI |=> product_id[15:8] == $past(mcu_req.wdata))
        else $error("product id high byte not stored");

    AST_REL_HIGH_STORE: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        wr_hit && idx == uhcr_pkg::IDX_REL_HI |=> release_number[15:8] == $past(mcu_req.wdata))
        else $error("release number high byte not stored");

    AST_REL_LOW_STORE: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        wr_hit && idx == uhcr_pkg::IDX_REL_LO |=> release_number[7:0] == $past(mcu_req.wdata))
        else $error("release number low byte not stored");

    AST_ROUTE5: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        seq_ctrl_write(8'ha0) |=> route_function_to_port5 && !port_on_hub[4] && !port_on_hub[0]
        && port_on_hub[3:1] == 3'h7 && hub_requests_accept)
        else $error("port 5 routing wrong");

    AST_ROUTE4: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        seq_ctrl_write(8'h10) |=> !port_on_hub[3] && !port_on_hub[0] && port_on_hub[4]
        && !hub_requests_accept)
        else $error("port 4 routing wrong");

    AST_ROUTE3: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        seq_ctrl_write(8'h88) |=> route_function_to_port3 && !port_on_hub[2] && !port_on_hub[0]
        && xcvr_enable[2] && !port_enabled[1])
        else $error("port 3 routing wrong");

    AST_ROUTE2_XCVR: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        seq_ctrl_write(8'h84) |=> !port_on_hub[1] && xcvr_enable[1] && xcvr_enable[0]
        && !port_enabled[0])
        else $error("port 2 routing wrong");

    AST_ROUTE_DISABLES_PORT: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        route_function_to_port4 |-> !port_enabled[2] && xcvr_enable[3])
        else $error("routed port 4 left under host control");

    AST_PORT_ENABLE: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        hub_requests_accept && host_port_enable[2] && !s_d.ctrl[4] && s_d.ctrl[7]
        |=> port_enabled[2] ##0 xcvr_enable[3])
        else $error("host port enable not honoured");

    AST_HOLD_CLEARS_PORTS: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        !hub_controller_hold_n |-> port_enabled == 4'h0)
        else $error("port left enabled while held");

    AST_HOLD_STATE: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        seq_ctrl_write(8'h00) |=> !hub_requests_accept && port_on_hub == 5'h1f
        && xcvr_enable == 5'h00)
        else $error("hub not fully held after control cleared");

    AST_XCVR_UPSTREAM: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        xcvr_enable[0] == hub_controller_hold_n)
        else $error("upstream transceiver does not follow hub hold");

    AST_LATE_STICKY: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        setup_late |=> setup_late && !setup_window_open)
        else $error("late setup flag lost");

    AST_RSVD_READ: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        rd_hit && idx == uhcr_pkg::IDX_RSVD |=> mcu_rvalid && mcu_rdata == 8'h00)
        else $error("reserved slot read non-zero");

endmodule // uhcr_regs

// ==== bench/uhcr_host_model.sv ====
module uhcr_host_model (
    input logic sys_clk,
    output uhcr_pkg::uhcr_token_t token,
    output logic [3:0] host_port_enable,
    output logic [3:0] host_port_disable
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        token = '0;
        host_port_enable = 4'h0;
        host_port_disable = 4'h0;
    end

    // Tests call this both while the hub is still held and once firmware setup is done
    task automatic send_token(input logic [3:0] pid, input logic [6:0] addr);
        @(posedge sys_clk) #1;
        token = '{valid: 1'b1, pid: pid, addr: addr};
        @(posedge sys_clk) #1;
        // A released bus keeps no stale token fields
        token = '{valid: 1'b0, pid: ~pid, addr: ~addr};
    endtask

    task automatic port_req(input logic [3:0] en, input logic [3:0] dis);
        @(posedge sys_clk) #1;
        host_port_enable = en;
        host_port_disable = dis;
        @(posedge sys_clk) #1;
        host_port_enable = 4'h0;
        host_port_disable = 4'h0;
    endtask
endmodule // uhcr_host_model

// ==== bench/testbench.sv ====
module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int SETUP_N = 50;
    localparam logic [6:0] HUB_ADDR = 7'h12;
    localparam logic [6:0] BAY_ADDR = 7'h34;

    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    uhcr_pkg::uhcr_mcu_req_t mcu_req = '0;
    uhcr_pkg::uhcr_token_t token;
    logic [3:0] host_port_enable;
    logic [3:0] host_port_disable;
    logic [7:0] mcu_rdata;
    logic mcu_rvalid;
    logic hub_ep_select;
    logic bay_ep_select;
    logic [15:0] vendor_id;
    logic [15:0] product_id;
    logic [15:0] release_number;
    logic hub_controller_hold_n;
    logic hub_requests_accept;
    logic route_function_to_port5;
    logic route_function_to_port4;
    logic route_function_to_port3;
    logic route_function_to_port2;
    logic [4:0] port_on_hub;
    logic [3:0] port_enabled;
    logic [4:0] xcvr_enable;
    logic setup_window_open;
    logic setup_late;
    int failures = 0;
    int comparisons = 0;
    logic [7:0] ids [6] = '{8'h2b, 8'h1a, 8'hc4, 8'h3d, 8'h01, 8'h02};
    logic [3:0] pids [3] = '{uhcr_pkg::PID_SETUP, uhcr_pkg::PID_IN, uhcr_pkg::PID_OUT};

    always #5 sys_clk = ~sys_clk;

    uhcr_regs #(.SETUP_CYCLES(SETUP_N)) u_uhcr_regs (
        .sys_clk(sys_clk), .nrst(nrst), .mcu_req(mcu_req), .mcu_rdata(mcu_rdata),
        .mcu_rvalid(mcu_rvalid), .token(token), .hub_dev_addr(HUB_ADDR),
        .bay_dev_addr(BAY_ADDR), .host_port_enable(host_port_enable),
        .host_port_disable(host_port_disable), .hub_ep_select(hub_ep_select),
        .bay_ep_select(bay_ep_select), .vendor_id(vendor_id), .product_id(product_id),
        .release_number(release_number), .hub_controller_hold_n(hub_controller_hold_n),
        .hub_requests_accept(hub_requests_accept),
        .route_function_to_port5(route_function_to_port5),
        .route_function_to_port4(route_function_to_port4),
        .route_function_to_port3(route_function_to_port3),
        .route_function_to_port2(route_function_to_port2), .port_on_hub(port_on_hub),
        .port_enabled(port_enabled), .xcvr_enable(xcvr_enable),
        .setup_window_open(setup_window_open), .setup_late(setup_late)
    );

    uhcr_host_model u_uhcr_host_model (
        .sys_clk(sys_clk), .token(token), .host_port_enable(host_port_enable),
        .host_port_disable(host_port_disable)
    );

    task automatic stop_test;
        if (failures == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk) #1;
        mcu_req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk) #1;
        mcu_req = '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask

    // Answer stands one cycle only, so it is sampled just after the taking edge
    task automatic rd(input logic [15:0] a, input logic [7:0] exp, input logic ok);
        @(posedge sys_clk) #1;
        mcu_req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk) #1;
        mcu_req = '{addr: ~a, wdata: 8'hff, wr: 1'b0, rd: 1'b0};
        check(16'(mcu_rvalid), 16'(ok));
        check(16'(mcu_rdata), 16'(exp));
    endtask

    task automatic tok(input logic [3:0] pid, input logic [6:0] a, input logic hub, input logic bay);
        u_uhcr_host_model.send_token(pid, a);
        check(16'({hub_ep_select, bay_ep_select}), 16'({hub, bay}));
    endtask

    initial begin
        #200000;
        failures++;
        stop_test();
    end

    initial begin
        repeat (3) @(posedge sys_clk);
        #1 nrst = 1'b1;
        check(16'({hub_controller_hold_n, hub_requests_accept}), 16'h0);
        check(16'({port_on_hub, xcvr_enable, setup_window_open}), 16'h7c1);
        for (int i = 0; i < 8; i++) rd(16'h7fa0 + 16'(i), 8'h00, 1'b1);
        tok(uhcr_pkg::PID_IN, HUB_ADDR, 1'b0, 1'b0);
        tok(uhcr_pkg::PID_SETUP, BAY_ADDR, 1'b0, 1'b1);
        u_uhcr_host_model.port_req(4'h1, 4'h0);
        check(16'(port_enabled), 16'h0);
        repeat (SETUP_N) @(posedge sys_clk);
        #1 check(16'({setup_window_open, setup_late}), 16'h1);
        // Each byte is read straight back, and all of them again once the block is full
        for (int i = 0; i < 6; i++) begin
            wr(16'h7fa0 + 16'(i), ids[i]);
            rd(16'h7fa0 + 16'(i), ids[i], 1'b1);
        end
        wr(16'h7fa7, 8'h5a);
        wr(16'h7fa8, 8'h77);
        for (int i = 0; i < 6; i++) rd(16'h7fa0 + 16'(i), ids[i], 1'b1);
        rd(16'h7fa7, 8'h00, 1'b1);
        rd(16'h7fa8, 8'h00, 1'b0);
        rd(16'h7f9f, 8'h00, 1'b0);
        check(vendor_id, 16'h1a2b);
        check(product_id, 16'h3dc4);
        check(release_number, 16'h0201);
        wr(16'h7fa6, 8'h80);
        check(16'({hub_controller_hold_n, hub_requests_accept}), 16'h3);
        check(16'({port_on_hub, xcvr_enable}), 16'h3e1);
        for (int i = 0; i < 3; i++) tok(pids[i], HUB_ADDR, 1'b1, 1'b0);
        tok(4'h5, HUB_ADDR, 1'b0, 1'b0);
        tok(uhcr_pkg::PID_OUT, HUB_ADDR ^ 7'h01, 1'b0, 1'b0);
        tok(uhcr_pkg::PID_IN, BAY_ADDR, 1'b0, 1'b1);
        u_uhcr_host_model.port_req(4'h1, 4'h1);
        check(16'({port_enabled, xcvr_enable}), 16'h23);
        u_uhcr_host_model.port_req(4'h0, 4'h1);
        check(16'({port_enabled, xcvr_enable}), 16'h01);
        u_uhcr_host_model.port_req(4'h4, 4'h0);
        check(16'({port_enabled, xcvr_enable}), 16'h89);
        u_uhcr_host_model.port_req(4'h0, 4'h4);
        check(16'(port_enabled), 16'h0);
        rd(16'h7fa6, 8'h80, 1'b1);
        for (int b = 2; b < 6; b++) begin
            wr(16'h7fa6, 8'h80 | (8'h01 << b));
            check(16'({route_function_to_port5, route_function_to_port4, route_function_to_port3,
                route_function_to_port2}), 16'h1 << (b - 2));
            check(16'(port_on_hub), 16'(5'h1e & ~(5'h01 << (b - 1))));
            check(16'(xcvr_enable), 16'(5'h01 | (5'h01 << (b - 1))));
            u_uhcr_host_model.port_req(4'h1 << (b - 2), 4'h0);
            check(16'(port_enabled), 16'h0);
        end
        u_uhcr_host_model.port_req(4'h2, 4'h0);
        check(16'(port_enabled), 16'h2);
        wr(16'h7fa6, 8'h00);
        check(16'({hub_controller_hold_n, port_on_hub, port_enabled}), 16'h1f0);
        tok(uhcr_pkg::PID_SETUP, HUB_ADDR, 1'b0, 1'b0);
        wr(16'h7fa6, 8'h10);
        check(16'({route_function_to_port4, hub_requests_accept, port_on_hub}),
            16'h56);
        stop_test();
    end
endmodule // testbench
